// ==== drp_top.sv ====
/*
  Duty reference profile bank: six profile words behind an Avalon-MM slave, and the
  logic that turns the input duty command into run, direction, control-mode and reference.
  Assumes the duty command comes from logic on the same clock, sampled on duty_valid.
*/
`timescale 1ns/10ps

// Behaviour
// - shape field picks reference, linear, staircase, forward-reverse
// - first start duty is eight bits, value/256
// - first stop duty is eight bits, value/256
// - first clamp duty clamps the reference
// - duty breakpoint A split five high, three low
// - duty breakpoints B, C, D in word two
// - duty breakpoint E split four high, four low
// - second start, stop, clamp duties in word three
// - hysteresis code adds 0 to 3 percent
// - first stop, clamp targets and reference A
// - reference B split seven high, one low
// - reference breakpoints C, D, E in word five
// - reference mode starts above minimum duty threshold
// - mixed mode selects modulation index around C
// - filter bit enables 0.4 percent input filter
// - second stop and clamp targets in word six
// - hall angle equals value times 360/63
module drp_top (
  input wire logic clk,                                     // core clock, 25 MHz
  input wire logic rst_b,                                   // synchronous reset, active low
  input wire logic [drp_pkg::DRP_ADDR_W-1:0] avs_address,   // byte address
  input wire logic avs_read,                                // read request
  input wire logic avs_write,                               // write request
  input wire logic [31:0] avs_writedata,                    // write data
  input wire logic [3:0] avs_byteenable,                    // byte lanes of a write
  output logic [31:0] avs_readdata,                         // read data
  output logic avs_waitrequest,                             // stall, high until answered
  input wire logic [7:0] duty_in,                           // duty command, value/256
  input wire logic duty_valid,                              // duty_in is new this cycle
  output logic [7:0] ref_out,                               // reference, value/256 of max
  output logic motor_run,                                   // motor driven
  output logic motor_reverse,                               // running in reverse
  output logic mod_index_ctrl,                              // modulation index control chosen
  output logic [8:0] hall_angle_deg                         // hall offset angle, degrees
);
  import drp_pkg::*;

  // ===========================================================
  // state
  drp_state_t s_r;
  drp_state_t s_nxt;

  // ===========================================================
  // profile fields
  drp_shape_t shape;
  logic [7:0] start1, stop1, clamp1, start2, stop2, clamp2;
  logic [7:0] soff1, sclamp1, soff2, sclamp2;
  logic [4:0][7:0] dp;
  logic [4:0][7:0] rp;
  logic [7:0] hys;
  logic [7:0] minthr;
  logic [1:0] mix;
  logic filt;
  logic [5:0] hall;
  logic [7:0] d;

  assign shape = drp_shape_t'(s_r.words[0][DRP_SHAPE_LSB +: 2]);
  assign start1 = s_r.words[0][DRP_START1_LSB +: 8];
  assign stop1 = s_r.words[0][DRP_STOP1_LSB +: 8];
  assign clamp1 = s_r.words[0][DRP_CLAMP1_LSB +: 8];
  assign dp[0] = {s_r.words[0][DRP_DA_HI_LSB +: 5], s_r.words[1][DRP_DA_LO_LSB +: 3]};
  assign dp[1] = s_r.words[1][DRP_DB_LSB +: 8];
  assign dp[2] = s_r.words[1][DRP_DC_LSB +: 8];
  assign dp[3] = s_r.words[1][DRP_DD_LSB +: 8];
  assign dp[4] = {s_r.words[1][DRP_DE_HI_LSB +: 4], s_r.words[2][DRP_DE_LO_LSB +: 4]};
  assign start2 = s_r.words[2][DRP_START2_LSB +: 8];
  assign stop2 = s_r.words[2][DRP_STOP2_LSB +: 8];
  assign clamp2 = s_r.words[2][DRP_CLAMP2_LSB +: 8];
  assign hys = DRP_HYS_TAB[s_r.words[2][DRP_HYS_LSB +: 2]];
  assign soff1 = s_r.words[3][DRP_SOFF1_LSB +: 8];
  assign sclamp1 = s_r.words[3][DRP_SCLAMP1_LSB +: 8];
  assign rp[0] = s_r.words[3][DRP_RA_LSB +: 8];
  assign rp[1] = {s_r.words[3][DRP_RB_HI_LSB +: 7], s_r.words[4][DRP_RB_LO_BIT]};
  assign rp[2] = s_r.words[4][DRP_RC_LSB +: 8];
  assign rp[3] = s_r.words[4][DRP_RD_LSB +: 8];
  assign rp[4] = s_r.words[4][DRP_RE_LSB +: 8];
  assign minthr = DRP_MIN_TAB[s_r.words[4][DRP_MIN_LSB +: 2]];
  assign mix = s_r.words[4][DRP_MIX_LSB +: 2];
  assign filt = s_r.words[4][DRP_FILT_BIT];
  assign soff2 = s_r.words[5][DRP_SOFF2_LSB +: 8];
  assign sclamp2 = s_r.words[5][DRP_SCLAMP2_LSB +: 8];
  assign hall = s_r.words[5][DRP_HALL_LSB +: 6];
  assign d = s_r.duty_f;

  // straight line through (x0,y0) and (x1,y1); a zero-width span yields y0
  function automatic logic [7:0] drp_interp(input logic [7:0] x, input logic [7:0] x0, input logic [7:0] y0,
                                            input logic [7:0] x1, input logic [7:0] y1);
    logic signed [17:0] dy;
    logic signed [17:0] dx;
    logic signed [17:0] den;
    logic signed [17:0] q;
    logic signed [17:0] y;
    dy = $signed({10'h000, y1}) - $signed({10'h000, y0});
    dx = $signed({10'h000, 8'(x - x0)});
    den = $signed({10'h000, 8'(x1 - x0)});
    q = (den == 18'sh00000) ? 18'sh00000 : 18'(dy * dx) / den;
    y = $signed({10'h000, y0}) + q;
    return y[7:0];
  endfunction : drp_interp

  // ===========================================================
  // next state
  logic hit;
  logic [2:0] sel;
  logic [31:0] rd;
  logic [7:0] diff;
  logic [7:0] lin_ref;
  logic [7:0] stair_ref;
  logic [7:0] prof;
  logic [8:0] d9;
  logic [8:0] d_hys;
  logic [8:0] mid_hi;

  always_comb begin
    s_nxt = s_r;
    hit = 1'b0;
    sel = 3'h0;
    rd = 32'h00000000;
    diff = 8'h00;
    lin_ref = rp[0];
    stair_ref = rp[0];
    d9 = {1'b0, d};
    d_hys = 9'({1'b0, d} + {1'b0, hys});
    mid_hi = 9'({1'b0, dp[2]} + {1'b0, hys});

    // bus slave: answer one cycle after the request, commit a write on the answering edge
    for (int i = 0; i < DRP_NWORDS; i++) begin
      if (avs_address[DRP_ADDR_W-1:2] == DRP_IDX[i]) begin
        hit = 1'b1;
        sel = 3'(i);
      end
    end
    if (hit) begin
      rd = {^s_r.words[sel][DRP_PARITY_BIT-1:0], s_r.words[sel][DRP_PARITY_BIT-1:0]};
    end
    if ((avs_read || avs_write) && s_r.wait_r) begin
      s_nxt.wait_r = 1'b0;
      s_nxt.rdata = avs_read ? rd : 32'h00000000;
    end else if ((avs_read || avs_write) && !s_r.wait_r) begin
      s_nxt.wait_r = 1'b1;
      if (avs_write && hit) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            s_nxt.words[sel][8*b +: 8] = avs_writedata[8*b +: 8];
          end
        end
        s_nxt.words[sel] = s_nxt.words[sel] & DRP_WMASK[sel];
      end
    end

    // small changes are ignored while filtering, one lsb is about 0.4 percent
    if (duty_valid) begin
      diff = (duty_in >= s_r.duty_f) ? 8'(duty_in - s_r.duty_f) : 8'(s_r.duty_f - duty_in);
      if (!(filt && diff <= DRP_FILT_BAND)) begin
        s_nxt.duty_f = duty_in;
      end
    end

    // segment search relies on ascending breakpoints; otherwise the lowest point is used
    if (d >= dp[4]) begin
      lin_ref = rp[4];
      stair_ref = rp[4];
    end
    for (int i = 0; i < 4; i++) begin
      if (d >= dp[i] && d < dp[i+1]) begin
        lin_ref = drp_interp(d, dp[i], rp[i], dp[i+1], rp[i+1]);
        stair_ref = rp[i];
      end
    end
    prof = (shape == DRP_SHAPE_STAIR) ? stair_ref : lin_ref;

    // run state; hysteresis widens each start and stop decision except the reference-mode start, which compares d with minthr alone
    unique case (s_r.run)
      DRP_RUN_STOP: begin
        if (shape == DRP_SHAPE_REF) begin
          if (d > minthr) s_nxt.run = DRP_RUN_FWD;
        end else if (d9 > 9'({1'b0, start1} + {1'b0, hys})) begin
          s_nxt.run = DRP_RUN_FWD;
        end else if (shape == DRP_SHAPE_FR && d_hys < {1'b0, start2}) begin
          s_nxt.run = DRP_RUN_REV;
        end
      end
      DRP_RUN_FWD: begin
        if (shape == DRP_SHAPE_REF) begin
          if (d_hys < {1'b0, minthr}) s_nxt.run = DRP_RUN_STOP;
        end else if (d_hys < {1'b0, stop1}) begin
          s_nxt.run = DRP_RUN_STOP;
        end
      end
      DRP_RUN_REV: begin
        if (shape != DRP_SHAPE_FR || d9 > 9'({1'b0, stop2} + {1'b0, hys})) begin
          s_nxt.run = DRP_RUN_STOP;
        end
      end
      default: s_nxt.run = DRP_RUN_STOP;
    endcase
    s_nxt.run_on = (s_nxt.run != DRP_RUN_STOP);
    s_nxt.rev = (s_nxt.run == DRP_RUN_REV);

    // reference follows the state the motor is entering
    if (s_nxt.run == DRP_RUN_STOP) begin
      s_nxt.refv = 8'h00;
    end else if (shape == DRP_SHAPE_REF) begin
      s_nxt.refv = d;
    end else if (s_nxt.run == DRP_RUN_REV) begin
      if (d <= clamp2) s_nxt.refv = sclamp2;
      else if (d >= stop2) s_nxt.refv = soff2;
      else s_nxt.refv = drp_interp(d, clamp2, sclamp2, stop2, soff2);
    end else if (d >= clamp1) begin
      s_nxt.refv = sclamp1;
    end else if (d <= stop1) begin
      s_nxt.refv = soff1;
    end else begin
      s_nxt.refv = prof;
    end

    // mixed control mode only exists for linear and staircase shapes
    if ((shape == DRP_SHAPE_LIN || shape == DRP_SHAPE_STAIR) && mix == DRP_MIX_MI_HIGH) begin
      if (d9 > mid_hi) s_nxt.mi = 1'b1;
      else if (d_hys < {1'b0, dp[2]}) s_nxt.mi = 1'b0;
    end else if ((shape == DRP_SHAPE_LIN || shape == DRP_SHAPE_STAIR) && mix == DRP_MIX_MI_LOW) begin
      if (d9 > mid_hi) s_nxt.mi = 1'b0;
      else if (d_hys < {1'b0, dp[2]}) s_nxt.mi = 1'b1;
    end else begin
      s_nxt.mi = 1'b0;
    end

    s_nxt.hall = 9'((16'({10'h000, hall}) * DRP_HALL_FULL) / DRP_HALL_STEPS);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_r <= DRP_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ===========================================================
  // outputs
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.wait_r;
  assign ref_out = s_r.refv;
  assign motor_run = s_r.run_on;
  assign motor_reverse = s_r.rev;
  assign mod_index_ctrl = s_r.mi;
  assign hall_angle_deg = s_r.hall;

  // ===========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle late");

  property p_write_word1;
    avs_write && !avs_waitrequest && avs_address == 10'h250 && avs_byteenable == 4'hf
      |=> s_r.words[0][30:0] == $past(avs_writedata[30:0]) && !s_r.words[0][31];
  endproperty
  a_write_word1: assert property (p_write_word1) else $error("word one write lost");

  property p_read_word6;
    avs_read && avs_waitrequest && avs_address == 10'h278
      |=> avs_readdata[8:0] == 9'h000 && avs_readdata[30:15] == s_r.words[5][30:15];
  endproperty
  a_read_word6: assert property (p_read_word6) else $error("word six readback wrong");

  property p_refmode_start;
    shape == DRP_SHAPE_REF && s_r.run == DRP_RUN_STOP && d > minthr |=> motor_run && ref_out == $past(d);
  endproperty
  a_refmode_start: assert property (p_refmode_start) else $error("reference mode did not start");

  property p_hys_hold;
    shape == DRP_SHAPE_LIN && s_r.run == DRP_RUN_STOP && {1'b0, d} <= 9'({1'b0, start1} + {1'b0, hys})
      |=> !motor_run;
  endproperty
  a_hys_hold: assert property (p_hys_hold) else $error("started inside hysteresis band");

  property p_clamp;
    shape == DRP_SHAPE_LIN && s_r.run == DRP_RUN_FWD && d >= clamp1 && d > stop1
      |=> motor_run && ref_out == $past(sclamp1);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp reference not applied");

  property p_stair_a;
    shape == DRP_SHAPE_STAIR && s_r.run == DRP_RUN_FWD && d >= dp[0] && d < dp[1] && dp[1] < dp[2]
      && dp[2] < dp[3] && dp[3] < dp[4] && d < clamp1 && d > stop1
      |=> ref_out == $past({s_r.words[3][14:7]});
  endproperty
  a_stair_a: assert property (p_stair_a) else $error("staircase step A wrong");

  property p_mix_high;
    shape == DRP_SHAPE_LIN && mix == DRP_MIX_MI_HIGH && {1'b0, d} > 9'({1'b0, dp[2]} + {1'b0, hys})
      |=> mod_index_ctrl;
  endproperty
  a_mix_high: assert property (p_mix_high) else $error("modulation index not selected");

  property p_filter_hold;
    filt && duty_valid && d != 8'hff && (duty_in == d || duty_in == 8'(d + 8'h01)) |=> $stable(s_r.duty_f);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter passed a small step");

  property p_reverse;
    shape == DRP_SHAPE_FR && s_r.run == DRP_RUN_STOP && {1'b0, d} <= 9'({1'b0, start1} + {1'b0, hys})
      && 9'({1'b0, d} + {1'b0, hys}) < {1'b0, start2} |=> motor_run && motor_reverse;
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse start missed");

  property p_hall_full;
    hall == 6'h3f [*2] |-> hall_angle_deg == 9'h168;
  endproperty
  a_hall_full: assert property (p_hall_full) else $error("hall angle scale wrong");

  // still running but at or below the first stop duty: the stop target is used
  property p_stop_target;
    shape == DRP_SHAPE_LIN && s_r.run == DRP_RUN_FWD && d <= stop1 && d < clamp1 && d_hys >= {1'b0, stop1}
      |=> motor_run && ref_out == $past(soff1);
  endproperty
  a_stop_target: assert property (p_stop_target) else $error("stop target not applied");

  property p_rev_clamp;
    shape == DRP_SHAPE_FR && s_r.run == DRP_RUN_REV && d <= clamp2 && d9 <= 9'({1'b0, stop2} + {1'b0, hys})
      |=> motor_reverse && ref_out == $past(sclamp2);
  endproperty
  a_rev_clamp: assert property (p_rev_clamp) else $error("reverse clamp target not applied");

  property p_filter_pass;
    !filt && duty_valid |=> s_r.duty_f == $past(duty_in);
  endproperty
  a_filter_pass: assert property (p_filter_pass) else $error("unfiltered duty not taken");

  c_write_read: cover property (avs_write && !avs_waitrequest ##1 avs_read [*2]);
  c_lin_run: cover property (shape == DRP_SHAPE_LIN && motor_run ##[1:20] !motor_run);
  c_fr_rev: cover property (shape == DRP_SHAPE_FR && motor_reverse);
  c_mix_swap: cover property (mod_index_ctrl ##[1:50] !mod_index_ctrl);

endmodule : drp_top

// ==== drp_pkg.sv ====
/*
  Constants, field layout and state types of the duty reference profile bank.
  Assumes a single core clock domain and word-aligned Avalon-MM byte addressing.
*/
package drp_pkg;

  // ===========================================================
  // register map
  localparam int DRP_ADDR_W = 10;
  localparam int DRP_NWORDS = 6;
  // printed offsets are word indices; byte address is four times the index
  localparam logic [5:0][7:0] DRP_IDX = {8'h9e, 8'h9c, 8'h9a, 8'h98, 8'h96, 8'h94};
  localparam logic [5:0][31:0] DRP_WMASK = {32'h7ffffe00, 32'h7ffffffe, 32'h7fffffff,
                                            32'h7ffffffe, 32'h7fffffff, 32'h7fffffff};
  localparam logic [31:0] DRP_RESET = 32'h00000000;
  localparam int DRP_PARITY_BIT = 31;

  // ===========================================================
  // field positions (lsb of each field)
  localparam int DRP_SHAPE_LSB = 29;
  localparam int DRP_START1_LSB = 21;
  localparam int DRP_STOP1_LSB = 13;
  localparam int DRP_CLAMP1_LSB = 5;
  localparam int DRP_DA_HI_LSB = 0;
  localparam int DRP_DA_LO_LSB = 28;
  localparam int DRP_DB_LSB = 20;
  localparam int DRP_DC_LSB = 12;
  localparam int DRP_DD_LSB = 4;
  localparam int DRP_DE_HI_LSB = 0;
  localparam int DRP_DE_LO_LSB = 27;
  localparam int DRP_START2_LSB = 19;
  localparam int DRP_STOP2_LSB = 11;
  localparam int DRP_CLAMP2_LSB = 3;
  localparam int DRP_HYS_LSB = 1;
  localparam int DRP_SOFF1_LSB = 23;
  localparam int DRP_SCLAMP1_LSB = 15;
  localparam int DRP_RA_LSB = 7;
  localparam int DRP_RB_HI_LSB = 0;
  localparam int DRP_RB_LO_BIT = 30;
  localparam int DRP_RC_LSB = 22;
  localparam int DRP_RD_LSB = 14;
  localparam int DRP_RE_LSB = 6;
  localparam int DRP_MIN_LSB = 4;
  localparam int DRP_MIX_LSB = 2;
  localparam int DRP_FILT_BIT = 1;
  localparam int DRP_SOFF2_LSB = 23;
  localparam int DRP_SCLAMP2_LSB = 15;
  localparam int DRP_HALL_LSB = 9;

  // ===========================================================
  // scaled thresholds, one duty lsb is 100/256 percent
  localparam logic [3:0][7:0] DRP_HYS_TAB = {8'h08, 8'h05, 8'h03, 8'h00};
  localparam logic [3:0][7:0] DRP_MIN_TAB = {8'h1a, 8'h0d, 8'h08, 8'h03};
  localparam logic [7:0] DRP_FILT_BAND = 8'h01;
  localparam logic [15:0] DRP_HALL_FULL = 16'h0168;
  localparam logic [15:0] DRP_HALL_STEPS = 16'h003f;
  localparam logic [1:0] DRP_MIX_USER = 2'h0;
  localparam logic [1:0] DRP_MIX_MI_HIGH = 2'h1;
  localparam logic [1:0] DRP_MIX_MI_LOW = 2'h2;

  // ===========================================================
  // types
  typedef enum logic [1:0] {
    DRP_SHAPE_REF = 2'b00,
    DRP_SHAPE_LIN = 2'b01,
    DRP_SHAPE_STAIR = 2'b10,
    DRP_SHAPE_FR = 2'b11
  } drp_shape_t;

  typedef enum logic [1:0] {
    DRP_RUN_STOP = 2'b00,
    DRP_RUN_FWD = 2'b01,
    DRP_RUN_REV = 2'b10
  } drp_run_t;

  typedef struct packed {
    logic [5:0][31:0] words;
    logic wait_r;
    logic [31:0] rdata;
    logic [7:0] duty_f;
    drp_run_t run;
    logic run_on;
    logic rev;
    logic mi;
    logic [7:0] refv;
    logic [8:0] hall;
  } drp_state_t;

  localparam drp_state_t DRP_STATE_RST = '{words: {6{DRP_RESET}}, wait_r: 1'b1, rdata: 32'h00000000,
                                           duty_f: 8'h00, run: DRP_RUN_STOP, run_on: 1'b0, rev: 1'b0,
                                           mi: 1'b0, refv: 8'h00, hall: 9'h000};

endpackage : drp_pkg

// ==== drp_duty_src.sv ====
/*
  Duty command source standing in for the external controller.
  Assumes the bench raises go for one cycle with the wanted duty on val.
*/
`timescale 1ns/10ps

// ===========================================================
// duty command source
module drp_duty_src (
  input wire logic clk,        // core clock
  input wire logic rst_b,      // synchronous reset, active low
  input wire logic go,         // send val on the next cycle
  input wire logic [7:0] val,  // duty to send
  output logic [7:0] duty_in,  // duty command
  output logic duty_valid      // one-cycle strobe
);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      duty_in <= 8'h00;
      duty_valid <= 1'b0;
    end else if (go) begin
      duty_in <= val;
      duty_valid <= 1'b1;
    end else begin
      // unqualified: keep changing so a stale value is never taken for data
      duty_in <= ~duty_in;
      duty_valid <= 1'b0;
    end
  end
endmodule : drp_duty_src

// ==== drp_top_tb.sv ====
/*
  Self-checking bench of the duty reference profile bank.
  Assumes drp_pkg and drp_duty_src compiled first; one 25 MHz clock.
*/
`timescale 1ns/10ps

module drp_top_tb;
  import drp_pkg::*;

  typedef struct {logic [9:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} drp_reg_row_t;
  typedef struct {logic [1:0] sh; logic [7:0] d; logic run; logic rev; logic [7:0] r;} drp_duty_row_t;

  // ===========================================================
  // profile used throughout, breakpoints ascending, first stop below first start, second stop above second start
  localparam logic [7:0] ST1 = 8'h20, SP1 = 8'h18, CL1 = 8'hf0, ST2 = 8'h10, SP2 = 8'h1c, CL2 = 8'h0c;
  localparam logic [7:0] DA = 8'h43, DB = 8'h60, DC = 8'h80, DD = 8'ha0, DE = 8'hc5;
  localparam logic [7:0] RA = 8'h10, RB = 8'h31, RC = 8'h50, RD = 8'h70, RE = 8'h90;
  localparam logic [7:0] SO1 = 8'h05, SC1 = 8'hff, SO2 = 8'h20, SC2 = 8'he0;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [DRP_ADDR_W-1:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] duty_in;
  logic duty_valid;
  logic [7:0] ref_out;
  logic motor_run;
  logic motor_reverse;
  logic mod_index_ctrl;
  logic [8:0] hall_angle_deg;
  logic go = 1'b0;
  logic [7:0] val = 8'h00;
  logic [31:0] rd;
  logic [1:0] shape = 2'h0, hys = 2'h0, mn = 2'h3, mix = 2'h0;
  logic filt = 1'b0;
  logic [5:0] hall = 6'h00;
  int err_total = 0;
  int checks = 0;

  drp_reg_row_t rrows [9] = '{
    '{10'h250, 4'hf, 32'hffffffff, 32'hffffffff}, '{10'h258, 4'hf, 32'hffffffff, 32'hffffffff},
    '{10'h260, 4'hf, 32'hffffffff, 32'h7ffffffe}, '{10'h268, 4'hf, 32'hffffffff, 32'hffffffff},
    '{10'h270, 4'hf, 32'hffffffff, 32'h7ffffffe}, '{10'h278, 4'hf, 32'hffffffff, 32'h7ffffe00},
    '{10'h250, 4'h2, 32'h00000000, 32'hffff00ff}, '{10'h254, 4'hf, 32'hffffffff, 32'h00000000},
    '{10'h278, 4'hf, 32'h00000200, 32'h80000200}};
  drp_duty_row_t drows [22] = '{
    '{2'h0, 8'h1a, 0, 0, 8'h00}, '{2'h0, 8'h1b, 1, 0, 8'h1b}, '{2'h0, 8'h80, 1, 0, 8'h80},
    '{2'h0, 8'h19, 0, 0, 8'h00}, '{2'h1, 8'h20, 0, 0, 8'h00}, '{2'h1, 8'h21, 1, 0, 8'h10},
    '{2'h1, 8'h50, 1, 0, 8'h1e}, '{2'h1, 8'h60, 1, 0, 8'h31}, '{2'h1, 8'hc5, 1, 0, 8'h90},
    '{2'h1, 8'hf0, 1, 0, 8'hff}, '{2'h1, 8'h18, 1, 0, 8'h05}, '{2'h1, 8'h17, 0, 0, 8'h00},
    '{2'h2, 8'h21, 1, 0, 8'h10}, '{2'h2, 8'h50, 1, 0, 8'h10}, '{2'h2, 8'h7f, 1, 0, 8'h31},
    '{2'h2, 8'h80, 1, 0, 8'h50}, '{2'h2, 8'h17, 0, 0, 8'h00}, '{2'h3, 8'h08, 1, 1, 8'he0},
    '{2'h3, 8'h1c, 1, 1, 8'h20}, '{2'h3, 8'h1d, 0, 0, 8'h00}, '{2'h3, 8'h25, 1, 0, 8'h10},
    '{2'h3, 8'h10, 0, 0, 8'h00}};
  logic [7:0] thr [4] = '{8'h03, 8'h08, 8'h0d, 8'h1a};
  logic [7:0] hv [4] = '{8'h00, 8'h03, 8'h05, 8'h08};
  logic [5:0] hf [3] = '{6'h3f, 6'h01, 6'h20};
  logic [15:0] he [3] = '{16'h0168, 16'h0005, 16'h00b6};

  drp_top i_drp_top (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .duty_in(duty_in),
    .duty_valid(duty_valid), .ref_out(ref_out), .motor_run(motor_run), .motor_reverse(motor_reverse),
    .mod_index_ctrl(mod_index_ctrl), .hall_angle_deg(hall_angle_deg));
  drp_duty_src i_drp_duty_src (.clk(clk), .rst_b(rst_b), .go(go), .val(val), .duty_in(duty_in),
    .duty_valid(duty_valid));

  always #20 clk = ~clk;

  // ===========================================================
  // compare, bus and stimulus tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out

  // one idle edge before each request, so strobes are never set twice in one step
  task automatic bus(input logic wr, input logic [9:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic cfg();
    bus(1, 10'h250, 4'hf, {1'b0, shape, ST1, SP1, CL1, DA[7:3]});
    bus(1, 10'h258, 4'hf, {1'b0, DA[2:0], DB, DC, DD, DE[7:4]});
    bus(1, 10'h260, 4'hf, {1'b0, DE[3:0], ST2, SP2, CL2, hys, 1'b0});
    bus(1, 10'h268, 4'hf, {1'b0, SO1, SC1, RA, RB[7:1]});
    bus(1, 10'h270, 4'hf, {1'b0, RB[0], RC, RD, RE, mn, mix, filt, 1'b0});
    bus(1, 10'h278, 4'hf, {1'b0, SO2, SC2, hall, 9'h000});
  endtask : cfg

  // outputs settle two edges after the strobe; four gives margin
  task automatic duty(input logic [7:0] d);
    @(posedge clk);
    go <= 1'b1;
    val <= d;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : duty

  task automatic end_sim();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // ===========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(0, 10'h250 + 10'(8 * i), 4'hf, 32'h0);
      chk_reg(rd, 32'h00000000);
    end
    cfg();
    foreach (drows[i]) begin
      if (drows[i].sh !== shape) begin
        shape = drows[i].sh;
        cfg();
      end
      duty(drows[i].d);
      chk_out({15'h0, motor_run}, {15'h0, drows[i].run});
      chk_out({15'h0, motor_reverse}, {15'h0, drows[i].rev});
      chk_out({8'h0, ref_out}, {8'h0, drows[i].r});
    end
    shape = 2'h0;
    // park the duty at zero so a lower threshold written by cfg cannot start the motor early
    duty(8'h00);
    for (int c = 0; c < 4; c++) begin
      mn = c[1:0];
      cfg();
      duty(thr[c]);
      chk_out({15'h0, motor_run}, 16'h0000);
      duty(thr[c] + 8'h01);
      chk_out({15'h0, motor_run}, 16'h0001);
      duty(8'h00);
      chk_out({15'h0, motor_run}, 16'h0000);
    end
    for (int h = 0; h < 4; h++) begin
      hys = h[1:0];
      cfg();
      duty(8'h1b);
      duty(8'h1a - hv[h]);
      chk_out({15'h0, motor_run}, 16'h0001);
      duty(8'h19 - hv[h]);
      chk_out({15'h0, motor_run}, 16'h0000);
    end
    shape = 2'h1;
    hys = 2'h0;
    for (int m = 0; m < 3; m++) begin
      mix = m[1:0];
      cfg();
      duty(8'h81);
      chk_out({15'h0, mod_index_ctrl}, {15'h0, m == 1});
      duty(8'h7f);
      chk_out({15'h0, mod_index_ctrl}, {15'h0, m == 2});
    end
    shape = 2'h0;
    mix = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (i == 0 || i == 3) begin
        filt = (i == 0);
        cfg();
      end
      duty(8'h40 + 8'(i));
      chk_out({8'h0, ref_out}, (i == 1) ? 16'h0040 : 16'h0040 + 16'(i));
    end
    for (int i = 0; i < 3; i++) begin
      hall = hf[i];
      cfg();
      repeat (2) @(posedge clk);
      #1;
      chk_out({7'h0, hall_angle_deg}, he[i]);
    end
    foreach (rrows[i]) begin
      bus(1, rrows[i].a, rrows[i].be, rrows[i].d);
      bus(0, rrows[i].a, 4'hf, 32'h0);
      chk_reg(rd, rrows[i].e);
    end
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 10'h250, 4'hf, 32'h0);
    chk_reg(rd, 32'h00000000);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : drp_top_tb
